// file: hdl/gpsc_pkg.sv
// gpsc_pkg: constants shared by the front-end io and power control block
//
// Overview of operation
// - software sets each general io line independently as static input or output
// - inputs sampled and outputs updated only on a software read or write request
// - an output-configured general io line is driven push-pull, high and low
// - a disabled general io line floats, held low only by weak pull-down
// - during usb suspend every front-end output driver is disabled
// - usb indicator off when unplugged, suspended or disabled; on when active
// - activity indicator off idle, blinking while active, on while awaiting slave
// - at startup and on resume every front-end port is high impedance
// - auxiliary supply enabled on first request, off in suspend, back on next request
// - over-current cuts front power, stops io, tri-states lines until reboot
// - reference level chosen from five settings; io levels follow it
// - reference output off until a level is chosen or default taken; off in suspend
// - two-wire transactions: write only, read only, write then read same slave
package gpsc_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int unsigned IO_LINES        = 8;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned BLINK_HALF_MS   = 100;
    localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;

    // ----------------------------------------------------------------
    // reference level codes and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] REF_1V2          = 3'h0;
    localparam logic [2:0] REF_1V5          = 3'h1;
    localparam logic [2:0] REF_1V8          = 3'h2;
    localparam logic [2:0] REF_2V5          = 3'h3;
    localparam logic [2:0] REF_3V3          = 3'h4;
    localparam logic [2:0] REF_DEFAULT      = REF_3V3;
    localparam logic [7:0] DIR_RESET        = 8'h00;
    localparam logic [7:0] OUT_RESET        = 8'h00;

    // ----------------------------------------------------------------
    // two-wire transaction kinds
    // ----------------------------------------------------------------
    localparam logic [1:0] TW_WRITE         = 2'h0;
    localparam logic [1:0] TW_READ          = 2'h1;
    localparam logic [1:0] TW_WRITE_READ    = 2'h2;

    typedef enum logic [3:0] {
        GPSC_OFF     = 4'b0001,
        GPSC_IDLE    = 4'b0010,
        GPSC_ACTIVE  = 4'b0100,
        GPSC_TRIPPED = 4'b1000
    } gpsc_state_t;

    // a valid level code is one of the five settings
    function automatic logic ref_valid(input logic [2:0] code);
        ref_valid = (code <= REF_3V3);
    endfunction

endpackage

// file: hdl/gpsc_led.sv
// gpsc_led: usb and activity indicator decoding
`timescale 1ns/1ns
`default_nettype none
module gpsc_led #(
    parameter int unsigned BLINK_CYC = gpsc_pkg::BLINK_HALF_CYC
) (
    input  wire logic core_clk_i,
    input  wire logic resetn_i,
    input  wire logic usb_attached_i,
    input  wire logic usb_active_i,
    input  wire logic usb_suspend_i,
    input  wire logic xfer_active_i,
    input  wire logic slave_wait_i,
    output logic      usb_led_o,
    output logic      act_led_o
);
    logic [23:0] blink_cnt_q;
    logic        blink_q;

    // ----------------------------------------------------------------
    // free-running blink base
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            blink_cnt_q <= 24'h000000;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == 24'(BLINK_CYC - 1)) begin
            blink_cnt_q <= 24'h000000;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 24'h000001;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            usb_led_o <= 1'b0;
            act_led_o <= 1'b0;
        end else begin
            usb_led_o <= usb_attached_i & usb_active_i & ~usb_suspend_i;
            if (slave_wait_i)
                act_led_o <= 1'b1;
            else if (xfer_active_i)
                act_led_o <= blink_q;
            else
                act_led_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gpsc_io.sv
// gpsc_io: general io line bank with software-timed sampling and update
`timescale 1ns/1ns
`default_nettype none
module gpsc_io #(
    parameter int unsigned N = gpsc_pkg::IO_LINES
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         drive_allow_i,
    input  wire logic         dir_wr_i,
    input  wire logic [N-1:0] dir_i,
    input  wire logic         out_wr_i,
    input  wire logic [N-1:0] out_i,
    input  wire logic         rd_req_i,
    input  wire logic [N-1:0] general_io_line_i,
    output logic [N-1:0]      general_io_line_o,
    output logic [N-1:0]      general_io_line_oe_o,
    output logic [N-1:0]      general_io_line_pd_o,
    output logic [N-1:0]      static_input_line_o,
    output logic [N-1:0]      dir_o
);
    logic [N-1:0] dir_q;
    logic [N-1:0] out_q;
    logic [N-1:0] smp_q;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            dir_q <= N'(gpsc_pkg::DIR_RESET);
        else if (dir_wr_i)
            dir_q <= dir_i;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            out_q <= N'(gpsc_pkg::OUT_RESET);
        else if (out_wr_i)
            out_q <= out_i;
    end

    // sample only on request; no timed polling
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            smp_q <= '0;
        else if (rd_req_i)
            smp_q <= general_io_line_i & ~dir_q;
    end

    assign general_io_line_o    = out_q;
    assign general_io_line_oe_o = dir_q & {N{drive_allow_i}};
    assign general_io_line_pd_o = ~general_io_line_oe_o;
    assign static_input_line_o  = smp_q;
    assign dir_o                = dir_q;
endmodule
`default_nettype wire

// file: hdl/gpsc_top.sv
// gpsc_top: front-end io, power sequencing and protection control
`timescale 1ns/1ns
`default_nettype none
module gpsc_top #(
    parameter int unsigned N         = gpsc_pkg::IO_LINES,
    parameter int unsigned BLINK_CYC = gpsc_pkg::BLINK_HALF_CYC
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    // host link state
    input  wire logic         usb_attached_i,
    input  wire logic         usb_active_i,
    input  wire logic         usb_suspend_i,
    input  wire logic         host_req_i,
    // general io control
    input  wire logic         dir_wr_i,
    input  wire logic [N-1:0] dir_i,
    input  wire logic         out_wr_i,
    input  wire logic [N-1:0] out_i,
    input  wire logic         rd_req_i,
    input  wire logic [N-1:0] general_io_line_i,
    output logic [N-1:0]      general_io_line_o,
    output logic [N-1:0]      general_io_line_oe_o,
    output logic [N-1:0]      general_io_line_pd_o,
    output logic [N-1:0]      static_input_line_o,
    output logic [N-1:0]      dir_o,
    // reference level
    input  wire logic         ref_sel_wr_i,
    input  wire logic [2:0]   ref_sel_i,
    input  wire logic         ref_default_i,
    output logic              ref_en_o,
    output logic [2:0]        ref_level_o,
    output logic              io_level_valid_o,
    // power
    output logic              auxiliary_supply_output_en_o,
    output logic              front_power_en_o,
    input  wire logic         aux_overcurrent_i,
    input  wire logic         ref_overcurrent_i,
    output logic              overcurrent_o,
    // serial engines
    input  wire logic         tw_start_i,
    input  wire logic [1:0]   tw_kind_i,
    input  wire logic [6:0]   tw_addr_i,
    input  wire logic         tw_done_i,
    output logic              tw_go_o,
    output logic [1:0]        tw_kind_o,
    output logic [6:0]        tw_addr_o,
    output logic              tw_busy_o,
    output logic              tw_bad_kind_o,
    input  wire logic         spi_active_i,
    input  wire logic         spi_slave_wait_i,
    output logic              serial_drive_en_o,
    // indicators
    output logic              usb_led_o,
    output logic              act_led_o
);
    gpsc_pkg::gpsc_state_t state_q;
    gpsc_pkg::gpsc_state_t state_d;
    logic       trip_q;
    logic       aux_en_q;
    logic       ref_chosen_q;
    logic [2:0] ref_lvl_q;
    logic       tw_busy_q;
    logic [1:0] tw_kind_q;
    logic [6:0] tw_addr_q;
    logic       tw_go_q;
    logic       tw_bad_q;
    logic       drive_allow;
    logic       overcurrent;

    assign overcurrent = aux_overcurrent_i | ref_overcurrent_i;

    // ----------------------------------------------------------------
    // power state: off until first request, idle in suspend, tripped until reset
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            gpsc_pkg::GPSC_OFF: begin
                if (overcurrent)
                    state_d = gpsc_pkg::GPSC_TRIPPED;
                else if (host_req_i && !usb_suspend_i)
                    state_d = gpsc_pkg::GPSC_ACTIVE;
            end
            gpsc_pkg::GPSC_IDLE: begin
                if (overcurrent)
                    state_d = gpsc_pkg::GPSC_TRIPPED;
                else if (host_req_i && !usb_suspend_i)
                    state_d = gpsc_pkg::GPSC_ACTIVE;
            end
            gpsc_pkg::GPSC_ACTIVE: begin
                if (overcurrent)
                    state_d = gpsc_pkg::GPSC_TRIPPED;
                else if (usb_suspend_i)
                    state_d = gpsc_pkg::GPSC_IDLE;
            end
            gpsc_pkg::GPSC_TRIPPED: state_d = gpsc_pkg::GPSC_TRIPPED;
            default:                state_d = gpsc_pkg::GPSC_TRIPPED;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            state_q <= gpsc_pkg::GPSC_OFF;
        else
            state_q <= state_d;
    end

    // lines drive only while active; covers startup, resume, suspend, trip
    assign drive_allow = (state_q == gpsc_pkg::GPSC_ACTIVE) && !usb_suspend_i;

    // ----------------------------------------------------------------
    // supplies
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            aux_en_q <= 1'b0;
        else
            aux_en_q <= (state_d == gpsc_pkg::GPSC_ACTIVE);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            trip_q <= 1'b0;
        else if (overcurrent)
            trip_q <= 1'b1;
    end

    // ----------------------------------------------------------------
    // reference level selection
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ref_lvl_q    <= gpsc_pkg::REF_DEFAULT;
            ref_chosen_q <= 1'b0;
        end else if (ref_sel_wr_i && gpsc_pkg::ref_valid(ref_sel_i)) begin
            ref_lvl_q    <= ref_sel_i;
            ref_chosen_q <= 1'b1;
        end else if (ref_default_i) begin
            ref_lvl_q    <= gpsc_pkg::REF_DEFAULT;
            ref_chosen_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // two-wire transaction launch
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tw_busy_q <= 1'b0;
            tw_go_q   <= 1'b0;
            tw_bad_q  <= 1'b0;
            tw_kind_q <= gpsc_pkg::TW_WRITE;
            tw_addr_q <= 7'h00;
        end else begin
            tw_go_q  <= 1'b0;
            tw_bad_q <= 1'b0;
            if (!drive_allow) begin
                tw_busy_q <= 1'b0;
            end else if (tw_busy_q) begin
                if (tw_done_i)
                    tw_busy_q <= 1'b0;
            end else if (tw_start_i) begin
                // a write-read keeps one address for both phases
                if (tw_kind_i == gpsc_pkg::TW_WRITE || tw_kind_i == gpsc_pkg::TW_READ ||
                    tw_kind_i == gpsc_pkg::TW_WRITE_READ) begin
                    tw_busy_q <= 1'b1;
                    tw_go_q   <= 1'b1;
                    tw_kind_q <= tw_kind_i;
                    tw_addr_q <= tw_addr_i;
                end else begin
                    tw_bad_q  <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // sub-blocks and outputs
    // ----------------------------------------------------------------
    gpsc_io #(
        .N (N)
    ) u_io (
        .core_clk_i           (core_clk_i),
        .resetn_i             (resetn_i),
        .drive_allow_i        (drive_allow),
        .dir_wr_i             (dir_wr_i),
        .dir_i                (dir_i),
        .out_wr_i             (out_wr_i),
        .out_i                (out_i),
        .rd_req_i             (rd_req_i),
        .general_io_line_i    (general_io_line_i),
        .general_io_line_o    (general_io_line_o),
        .general_io_line_oe_o (general_io_line_oe_o),
        .general_io_line_pd_o (general_io_line_pd_o),
        .static_input_line_o  (static_input_line_o),
        .dir_o                (dir_o)
    );

    gpsc_led #(
        .BLINK_CYC (BLINK_CYC)
    ) u_led (
        .core_clk_i     (core_clk_i),
        .resetn_i       (resetn_i),
        .usb_attached_i (usb_attached_i),
        .usb_active_i   (usb_active_i),
        .usb_suspend_i  (usb_suspend_i),
        .xfer_active_i  (drive_allow & (tw_busy_q | spi_active_i)),
        .slave_wait_i   (drive_allow & spi_slave_wait_i),
        .usb_led_o      (usb_led_o),
        .act_led_o      (act_led_o)
    );

    assign auxiliary_supply_output_en_o = aux_en_q & ~usb_suspend_i;
    assign ref_en_o          = ref_chosen_q & aux_en_q & ~usb_suspend_i;
    assign ref_level_o       = ref_lvl_q;
    assign io_level_valid_o  = ref_en_o;
    assign front_power_en_o  = (state_q != gpsc_pkg::GPSC_TRIPPED);
    assign overcurrent_o     = trip_q;
    assign serial_drive_en_o = drive_allow;
    assign tw_go_o           = tw_go_q;
    assign tw_kind_o         = tw_kind_q;
    assign tw_addr_o         = tw_addr_q;
    assign tw_busy_o         = tw_busy_q;
    assign tw_bad_kind_o     = tw_bad_q;
endmodule
`default_nettype wire

// file: verif/gpsc_top_assertions.sv
// gpsc_top_chk: port-level assertions for gpsc_top
`timescale 1ns/1ns
`default_nettype none
module gpsc_top_chk #(
    parameter int unsigned N = 8
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic usb_attached_i,
    input wire logic usb_active_i,
    input wire logic usb_suspend_i,
    input wire logic host_req_i,
    input wire logic rd_req_i,
    input wire logic [N-1:0] general_io_line_i,
    input wire logic [N-1:0] general_io_line_oe_o,
    input wire logic [N-1:0] general_io_line_pd_o,
    input wire logic [N-1:0] static_input_line_o,
    input wire logic [N-1:0] dir_o,
    input wire logic ref_en_o,
    input wire logic auxiliary_supply_output_en_o,
    input wire logic front_power_en_o,
    input wire logic aux_overcurrent_i,
    input wire logic ref_overcurrent_i,
    input wire logic overcurrent_o,
    input wire logic tw_start_i,
    input wire logic [1:0] tw_kind_i,
    input wire logic tw_go_o,
    input wire logic tw_busy_o,
    input wire logic spi_active_i,
    input wire logic spi_slave_wait_i,
    input wire logic serial_drive_en_o,
    input wire logic usb_led_o,
    input wire logic act_led_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_oe;
        general_io_line_oe_o == (dir_o & {N{serial_drive_en_o}});
    endproperty
    a_oe: assert property (p_oe)
        else $error("line enable does not follow direction");
    property p_pd;
        general_io_line_pd_o == ~general_io_line_oe_o;
    endproperty
    a_pd: assert property (p_pd)
        else $error("pull-down not on an undriven line");
    property p_rd;
        rd_req_i |=> static_input_line_o == ($past(general_io_line_i) & ~$past(dir_o));
    endproperty
    a_rd: assert property (p_rd)
        else $error("sampled input wrong");
    property p_rd_hold;
        !rd_req_i |=> $stable(static_input_line_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("input changed without a read");
    property p_susp;
        usb_suspend_i |-> general_io_line_oe_o == '0 && !serial_drive_en_o
            && !auxiliary_supply_output_en_o && !ref_en_o;
    endproperty
    a_susp: assert property (p_susp)
        else $error("driver on during suspend");
    property p_aux;
        host_req_i && !usb_suspend_i && !overcurrent_o && !aux_overcurrent_i
            && !ref_overcurrent_i |=> auxiliary_supply_output_en_o || usb_suspend_i;
    endproperty
    a_aux: assert property (p_aux)
        else $error("supply not on after request");
    property p_oc;
        aux_overcurrent_i || ref_overcurrent_i |=> overcurrent_o && !front_power_en_o
            && general_io_line_oe_o == '0 && !auxiliary_supply_output_en_o && !ref_en_o;
    endproperty
    a_oc: assert property (p_oc)
        else $error("no shutdown on overcurrent");
    property p_sticky;
        overcurrent_o |=> overcurrent_o && !front_power_en_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overcurrent flag cleared");
    property p_usb_led;
        1'b1 |=> usb_led_o == $past(usb_attached_i && usb_active_i && !usb_suspend_i);
    endproperty
    a_usb_led: assert property (p_usb_led)
        else $error("usb indicator wrong");
    property p_wait;
        spi_slave_wait_i && serial_drive_en_o |=> act_led_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("activity not solid while waiting");
    property p_idle;
        !spi_slave_wait_i && !spi_active_i && !tw_busy_o |=> !act_led_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("activity lit while idle");
    property p_tw;
        tw_start_i && serial_drive_en_o && !tw_busy_o && tw_kind_i != 2'h3
            |=> tw_go_o && tw_busy_o;
    endproperty
    a_tw: assert property (p_tw)
        else $error("transaction not launched");
    c_rd: cover property (rd_req_i);
    c_tw: cover property (tw_go_o);
    c_oc: cover property (overcurrent_o);
    c_blink: cover property ($rose(act_led_o) && spi_active_i);
endmodule
bind gpsc_top gpsc_top_chk #(.N(N)) i_chk (.*);
`default_nettype wire

// file: verif/gpsc_board_model.sv
// gpsc_board_model: target board side of the io lines and the two-wire engine
`timescale 1ns/1ns
`default_nettype none
module gpsc_board_model #(
    parameter int unsigned N = 8
) (
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic [N-1:0] dut_line_i,
    input  wire logic [N-1:0] dut_oe_i,
    input  wire logic [N-1:0] board_en_i,
    input  wire logic [N-1:0] board_val_i,
    input  wire logic         tw_go_i,
    input  wire logic [3:0]   tw_delay_i,
    output logic [N-1:0]      line_o,
    output logic              tw_done_o
);
    logic [3:0] cnt_q;
    logic       run_q;
    // device drive wins, then board; an undriven line sits on its pull-down
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (dut_oe_i[i])
                line_o[i] = dut_line_i[i];
            else if (board_en_i[i])
                line_o[i] = board_val_i[i];
            else
                line_o[i] = 1'b0;
        end
    end
    // delay lets the engine answer promptly or slowly
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run_q <= 1'b0;
            cnt_q <= 4'h0;
            tw_done_o <= 1'b0;
        end else begin
            tw_done_o <= 1'b0;
            if (tw_go_i) begin
                run_q <= 1'b1;
                cnt_q <= tw_delay_i;
            end else if (run_q && cnt_q == 4'h0) begin
                run_q <= 1'b0;
                tw_done_o <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verif/tb.sv
// tb: self-checking bench for gpsc_top
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int unsigned N = 8;
    logic core_clk_i, resetn_i, usb_attached_i, usb_active_i, usb_suspend_i, host_req_i;
    logic dir_wr_i, out_wr_i, rd_req_i, ref_sel_wr_i, ref_default_i, ref_en_o;
    logic io_level_valid_o, auxiliary_supply_output_en_o, front_power_en_o, overcurrent_o;
    logic aux_overcurrent_i, ref_overcurrent_i, tw_start_i, tw_done_i, tw_go_o, tw_busy_o;
    logic tw_bad_kind_o, spi_active_i, spi_slave_wait_i, serial_drive_en_o;
    logic usb_led_o, act_led_o;
    logic [N-1:0] dir_i, out_i, general_io_line_i, general_io_line_o, general_io_line_oe_o;
    logic [N-1:0] general_io_line_pd_o, static_input_line_o, dir_o, brd_en, brd_val;
    logic [2:0] ref_sel_i, ref_level_o;
    logic [1:0] tw_kind_i, tw_kind_o;
    logic [6:0] tw_addr_i, tw_addr_o;
    logic [3:0] tw_dly;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    gpsc_top #(.N(N), .BLINK_CYC(4)) i_dut (.*);
    gpsc_board_model #(.N(N)) i_brd (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .dut_line_i(general_io_line_o), .dut_oe_i(general_io_line_oe_o),
        .board_en_i(brd_en), .board_val_i(brd_val), .tw_go_i(tw_go_o),
        .tw_delay_i(tw_dly), .line_o(general_io_line_i), .tw_done_o(tw_done_i));
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic test_done();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard: the whole run needs about a hundred cycles
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic do_reset();
        resetn_i = 1'b0;
        tick(4);
        resetn_i = 1'b1;
        tick();
    endtask
    task automatic t_led();
        int tg;
        logic lv;
        for (int i = 0; i < 8; i++) begin
            {usb_attached_i, usb_active_i, usb_suspend_i} = 3'(i);
            tick();
            chk(usb_led_o, 16'(i == 6));
        end
        {usb_attached_i, usb_active_i, usb_suspend_i} = 3'h6;
        // activity only shows while the front end is powered
        pulse(host_req_i);
        spi_slave_wait_i = 1'b1;
        spi_active_i = 1'b1;
        tick();
        chk(act_led_o, 16'h1);
        spi_slave_wait_i = 1'b0;
        tg = 0;
        for (int i = 0; i < 16; i++) begin
            lv = act_led_o;
            tick();
            if (act_led_o !== lv) tg++;
        end
        chk(16'(tg >= 3 && tg <= 5), 16'h1);
        spi_active_i = 1'b0;
        tick();
        chk(act_led_o, 16'h0);
        // back to the unpowered state for the startup checks
        do_reset();
    endtask
    task automatic t_io();
        dir_i = 8'hff;
        pulse(dir_wr_i);
        chk(general_io_line_oe_o, 16'h00);
        chk({front_power_en_o, auxiliary_supply_output_en_o, ref_en_o, overcurrent_o}, 16'h8);
        pulse(host_req_i);
        chk({auxiliary_supply_output_en_o, ref_en_o}, 16'h2);
        chk(general_io_line_oe_o, 16'hff);
        dir_i = 8'h0f;
        out_i = 8'ha5;
        out_wr_i = 1'b1;
        pulse(dir_wr_i);
        out_wr_i = 1'b0;
        chk({general_io_line_oe_o, general_io_line_pd_o}, 16'h0ff0);
        chk(general_io_line_i[3:0], 16'h5);
        brd_en = 8'hf0;
        brd_val = 8'h9c;
        pulse(rd_req_i);
        chk(static_input_line_o, 16'h90);
        brd_val = 8'h6c;
        out_i = 8'h5a;
        pulse(out_wr_i);
        chk(general_io_line_i[3:0], 16'ha);
        chk(static_input_line_o, 16'h90);
        pulse(rd_req_i);
        chk(static_input_line_o, 16'h60);
    endtask
    task automatic t_ref();
        for (int c = 0; c < 8; c++) begin
            ref_sel_i = 3'(c);
            pulse(ref_sel_wr_i);
            chk(ref_level_o, (c > 4) ? 16'h4 : 16'(c));
            chk({ref_en_o, io_level_valid_o}, 16'h3);
            tick();
        end
        ref_sel_i = 3'h0;
        pulse(ref_sel_wr_i);
        pulse(ref_default_i);
        chk(ref_level_o, 16'h4);
    endtask
    task automatic t_tw();
        for (int k = 0; k < 4; k++) begin
            tw_kind_i = 2'(k);
            tw_addr_i = 7'h50 + 7'(k);
            tw_dly = 4'(k * 4);
            pulse(tw_start_i);
            chk({tw_go_o, tw_busy_o, tw_bad_kind_o}, (k == 3) ? 16'h1 : 16'h6);
            // a refused kind leaves the last accepted kind and address
            chk({tw_kind_o, tw_addr_o}, (k == 3) ? {2'h2, 7'h52} : {tw_kind_i, tw_addr_i});
            if (k == 1) begin
                tick();
                pulse(tw_start_i);
                chk(tw_go_o, 16'h0);
            end
            for (int i = 0; i < 20 && tw_busy_o !== 1'b0; i++) tick();
            chk(tw_busy_o, 16'h0);
        end
    endtask
    task automatic t_susp();
        usb_suspend_i = 1'b1;
        #1;
        chk(auxiliary_supply_output_en_o, 16'h0);
        tick();
        chk({general_io_line_oe_o, serial_drive_en_o, ref_en_o}, 16'h0);
        usb_suspend_i = 1'b0;
        tick();
        chk({general_io_line_oe_o, auxiliary_supply_output_en_o}, 16'h0);
        pulse(host_req_i);
        chk({general_io_line_oe_o, auxiliary_supply_output_en_o}, 16'h1f);
    endtask
    task automatic t_oc();
        for (int s = 1; s < 3; s++) begin
            dir_i = 8'hff;
            pulse(dir_wr_i);
            pulse(host_req_i);
            {ref_overcurrent_i, aux_overcurrent_i} = 2'(s);
            tick();
            {ref_overcurrent_i, aux_overcurrent_i} = 2'h0;
            pulse(host_req_i);
            chk({front_power_en_o, overcurrent_o, serial_drive_en_o}, 16'h2);
            chk({general_io_line_oe_o, general_io_line_pd_o}, 16'h00ff);
            chk({auxiliary_supply_output_en_o, ref_en_o}, 16'h0);
            do_reset();
            chk({front_power_en_o, overcurrent_o}, 16'h2);
        end
    endtask
    initial begin
        {usb_attached_i, usb_active_i, usb_suspend_i, host_req_i, dir_wr_i} = '0;
        {out_wr_i, rd_req_i, ref_sel_wr_i, ref_default_i, aux_overcurrent_i} = '0;
        {ref_overcurrent_i, tw_start_i, spi_active_i, spi_slave_wait_i} = '0;
        {dir_i, out_i, brd_en, brd_val, ref_sel_i, tw_kind_i, tw_addr_i, tw_dly} = '0;
        resetn_i = 1'b0;
        do_reset();
        t_led();
        t_io();
        t_ref();
        t_tw();
        t_susp();
        t_oc();
        test_done();
    end
endmodule
`default_nettype wire
